// ===== hw/wkc_filter.sv
/*
 * Per input crossing filter: a level change starts the selected filter time
 * and the new level is accepted only if it holds for the whole time.
 * Assumes the input is already synchronised to mclk.
 */
`timescale 1ns/1ns
module wkc_filter (
	input  wire logic                       mclk,
	input  wire logic                       rst_n,
	input  wire logic                       level_in,
	input  wire logic                       long_sel,
	input  wire logic                       sample_en,
	output logic                            level_out,
	output logic                            edge_pulse
);
	import wkc_pkg::*;

	logic [CNT_W-1:0] cnt;
	logic [CNT_W-1:0] next_cnt;
	logic             next_level_out;
	logic             next_edge_pulse;
	logic [CNT_W-1:0] limit;

	// ==========================================
	// Filter counter
	always_comb begin
		limit = long_sel ? CNT_W'(FILT_LONG_CYC) : CNT_W'(FILT_SHORT_CYC);
		next_cnt = '0;
		next_level_out = level_out;
		next_edge_pulse = 1'b0;
		// A crossing back inside the interval clears the count, so the next change restarts the filter time.
		if (sample_en && (level_in != level_out)) begin
			if (cnt + CNT_W'(1) >= limit) begin
				next_level_out = level_in;
				next_edge_pulse = 1'b1;
			end else begin
				next_cnt = cnt + CNT_W'(1);
			end
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			cnt <= '0;
			level_out <= 1'b0;
			edge_pulse <= 1'b0;
		end else begin
			cnt <= next_cnt;
			level_out <= next_level_out;
			edge_pulse <= next_edge_pulse;
		end
	end

	// ==========================================
	// Checks
	a_filter_min_hold: assert property (@(posedge mclk) disable iff (!rst_n)
		$rose(edge_pulse) |-> $past(level_in != level_out, 2))
		else $error("Edge accepted without a prior differing level.");
endmodule

// ===== hw/wkc_pkg.sv
/*
 * Package for the wake input configuration block: codes, field layouts,
 * filter times and the counts derived from them.
 * Assumes the block runs from the internal oscillator at 20 MHz.
 */
package wkc_pkg;
	// ==========================================
	// Clock and filter timing
	localparam int CLK_PERIOD_NS = 50;
	localparam int FILT_SHORT_US = 16;
	localparam int FILT_LONG_US  = 64;
	localparam int FILT_SHORT_CYC = (FILT_SHORT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int FILT_LONG_CYC  = (FILT_LONG_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CNT_W = 11;

	// ==========================================
	// Field layouts
	localparam int NUM_INPUTS = 3;
	localparam int FIELD_W    = 2;

	typedef logic [FIELD_W-1:0] wkc_field_t;

	// Pull selection codes.
	localparam wkc_field_t PULL_NONE = 2'h0;
	localparam wkc_field_t PULL_DOWN = 2'h1;
	localparam wkc_field_t PULL_UP   = 2'h2;
	localparam wkc_field_t PULL_AUTO = 2'h3;

	// Detection mode codes.
	localparam wkc_field_t DET_STATIC_SHORT = 2'h0;
	localparam wkc_field_t DET_STATIC_LONG  = 2'h1;
	localparam wkc_field_t DET_CYCLIC_ONE   = 2'h2;
	localparam wkc_field_t DET_CYCLIC_TWO   = 2'h3;

	// Operating modes as seen by this block.
	typedef enum logic [2:0] {
		WKC_MODE_NORMAL,
		WKC_MODE_STOP,
		WKC_MODE_SLEEP,
		WKC_MODE_FAILSAFE,
		WKC_MODE_RESTART,
		WKC_MODE_OTHER
	} wkc_mode_e;

	localparam logic [NUM_INPUTS-1:0] IN_ALL_ZERO = 3'h0;
	localparam logic [NUM_INPUTS-1:0] IN_ONE_TWO  = 3'h3;
	localparam logic [NUM_INPUTS-1:0] IN_THREE    = 3'h4;
endpackage

// ===== hw/wkc_top.sv
/*
 * Wake input configuration and measurement gating for three wake inputs.
 * Assumes the comparator outputs arrive asynchronously, the operating mode and
 * cycle timer sample strobes come from logic on mclk.
 */
//
// Contract
// - Pull code 00 none, 01 pull-down, 10 pull-up, 11 automatic switching.
// - Automatic mode pulls up on high level, down on low level.
// - Detect code 00 static 16us filter, 01 static 64us filter.
// - Detect code 10 cyclic timer one, 11 cyclic timer two, 16us filter.
// - After reset measurement is off, switch open, inputs one and two normal.
// - With measurement on, switch closes only in normal mode.
// - Measurement mode kills pulls and gates detection of inputs one and two.
// - Settings for inputs one and two stay writable but are ignored.
// - Measurement mode freezes wake and level status of inputs one and two.
// - Sleep with only inputs one/two enabled under measurement sets fault, restarts.
// - Both edges wake: interrupt in normal/stop, wake from sleep/fail-safe.
// - A crossing must hold for the whole filter time to count.
// - Level status shows present or last sampled level in normal and stop.
`timescale 1ns/1ns
module wkc_top
	import wkc_pkg::*;
(
	input  wire logic                         mclk,
	input  wire logic                         rst_n,
	input  wire logic [wkc_pkg::NUM_INPUTS-1:0] comp_in,
	input  wire logic [5:0]                   pull_config_reg,
	input  wire logic [5:0]                   filter_config_reg,
	input  wire logic [wkc_pkg::NUM_INPUTS-1:0] wake_enable_reg,
	input  wire logic                         measure_enable,
	input  wire wkc_pkg::wkc_mode_e           op_mode,
	input  wire logic                         sleep_cmd,
	input  wire logic                         cycle_timer_one_sample,
	input  wire logic                         cycle_timer_two_sample,
	input  wire logic [wkc_pkg::NUM_INPUTS-1:0] wake_flags_clear,
	output logic [wkc_pkg::NUM_INPUTS-1:0]    pull_up_en,
	output logic [wkc_pkg::NUM_INPUTS-1:0]    pull_down_en,
	output logic                              measure_switch,
	output logic [wkc_pkg::NUM_INPUTS-1:0]    wake_flags_primary,
	output logic [wkc_pkg::NUM_INPUTS-1:0]    pin_level_status,
	output logic                              wake_int_req,
	output logic                              wake_up_req,
	output logic                              cmd_fault,
	output logic                              restart_req
);
	import wkc_pkg::*;

	// ==========================================
	// Input synchroniser
	// The first stage feeds only the second; all logic reads the second.
	logic [NUM_INPUTS-1:0] sync_a;
	logic [NUM_INPUTS-1:0] sync_b;

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			sync_a <= '0;
			sync_b <= '0;
		end else begin
			sync_a <= comp_in;
			sync_b <= sync_a;
		end
	end

	function automatic wkc_field_t field_of(input logic [5:0] reg_v, input int idx);
		field_of = reg_v[idx*FIELD_W +: FIELD_W];
	endfunction

	// ==========================================
	// Per input detection path
	logic [NUM_INPUTS-1:0] gated;
	logic [NUM_INPUTS-1:0] filt_level;
	logic [NUM_INPUTS-1:0] filt_edge;
	logic [NUM_INPUTS-1:0] long_sel;
	logic [NUM_INPUTS-1:0] sample_en;
	logic                  normal_or_stop;

	assign normal_or_stop = (op_mode == WKC_MODE_NORMAL) || (op_mode == WKC_MODE_STOP);

	always_comb begin
		for (int i = 0; i < NUM_INPUTS; i++) begin
			// Inputs one and two are gated off while measuring.
			gated[i] = measure_enable && IN_ONE_TWO[i];
			// Only config 01 selects the long filter; cyclic modes use the short one.
			long_sel[i] = (field_of(filter_config_reg, i) == DET_STATIC_LONG);
			case (field_of(filter_config_reg, i))
				DET_CYCLIC_ONE: sample_en[i] = cycle_timer_one_sample && !gated[i];
				DET_CYCLIC_TWO: sample_en[i] = cycle_timer_two_sample && !gated[i];
				default:        sample_en[i] = !gated[i];
			endcase
		end
	end

	for (genvar g = 0; g < NUM_INPUTS; g++) begin : g_filt
		wkc_filter u_filt (
			.mclk       (mclk),
			.rst_n      (rst_n),
			.level_in   (sync_b[g]),
			.long_sel   (long_sel[g]),
			.sample_en  (sample_en[g]),
			.level_out  (filt_level[g]),
			.edge_pulse (filt_edge[g])
		);
	end

	// ==========================================
	// Pull sources
	logic [NUM_INPUTS-1:0] next_pull_up_en;
	logic [NUM_INPUTS-1:0] next_pull_down_en;

	always_comb begin
		for (int i = 0; i < NUM_INPUTS; i++) begin
			next_pull_up_en[i] = 1'b0;
			next_pull_down_en[i] = 1'b0;
			// Pull settings of gated inputs are kept but ignored.
			if (!gated[i]) begin
				case (field_of(pull_config_reg, i))
					PULL_NONE: begin end
					PULL_DOWN: next_pull_down_en[i] = 1'b1;
					PULL_UP:   next_pull_up_en[i] = 1'b1;
					PULL_AUTO: begin
						// Follows the filtered level so glitches do not toggle the source.
						next_pull_up_en[i] = filt_level[i];
						next_pull_down_en[i] = !filt_level[i];
					end
					default: begin end
				endcase
			end
		end
	end

	// ==========================================
	// Status, wake events and sleep check
	logic [NUM_INPUTS-1:0] next_wake_flags;
	logic [NUM_INPUTS-1:0] next_level_status;
	logic [NUM_INPUTS-1:0] wake_hit;
	logic                  next_wake_int_req;
	logic                  next_wake_up_req;
	logic                  next_cmd_fault;
	logic                  next_restart_req;
	logic                  next_measure_switch;
	logic [NUM_INPUTS-1:0] eff_enable;

	always_comb begin
		// Wake enables of gated inputs count for the sleep check only.
		eff_enable = wake_enable_reg & ~(measure_enable ? IN_ONE_TWO : IN_ALL_ZERO);
		wake_hit = filt_edge & eff_enable;
		// The set wins over a clear in the same cycle; gated inputs never set.
		next_wake_flags = (wake_flags_primary & ~wake_flags_clear) | wake_hit;
		next_level_status = pin_level_status;
		for (int i = 0; i < NUM_INPUTS; i++) begin
			if (normal_or_stop && !gated[i]) begin
				next_level_status[i] = filt_level[i];
			end
		end
		next_wake_int_req = normal_or_stop && (wake_hit != IN_ALL_ZERO);
		next_wake_up_req = ((op_mode == WKC_MODE_SLEEP) || (op_mode == WKC_MODE_FAILSAFE))
			&& (wake_hit != IN_ALL_ZERO);
		next_cmd_fault = cmd_fault;
		next_restart_req = 1'b0;
		// Only one/two enabled, none of input three: sleep would never wake.
		if (sleep_cmd && measure_enable && ((wake_enable_reg & IN_ONE_TWO) != IN_ALL_ZERO)
			&& ((wake_enable_reg & IN_THREE) == IN_ALL_ZERO)) begin
			next_cmd_fault = 1'b1;
			next_restart_req = 1'b1;
		end
		// Registered copy; the one cycle lag is the price of a flop-driven output.
		next_measure_switch = measure_enable && (op_mode == WKC_MODE_NORMAL);
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			pull_up_en <= '0;
			pull_down_en <= '0;
			measure_switch <= 1'b0;
			wake_flags_primary <= '0;
			pin_level_status <= '0;
			wake_int_req <= 1'b0;
			wake_up_req <= 1'b0;
			cmd_fault <= 1'b0;
			restart_req <= 1'b0;
		end else begin
			pull_up_en <= next_pull_up_en;
			pull_down_en <= next_pull_down_en;
			measure_switch <= next_measure_switch;
			wake_flags_primary <= next_wake_flags;
			pin_level_status <= next_level_status;
			wake_int_req <= next_wake_int_req;
			wake_up_req <= next_wake_up_req;
			cmd_fault <= next_cmd_fault;
			restart_req <= next_restart_req;
		end
	end

	// ==========================================
	// Checks
	a_switch_normal_only: assert property (@(posedge mclk) disable iff (!rst_n)
		measure_switch |-> $past(measure_enable && op_mode == WKC_MODE_NORMAL))
		else $error("Measure switch closed outside normal mode.");

	a_switch_follows: assert property (@(posedge mclk) disable iff (!rst_n)
		(measure_enable && op_mode == WKC_MODE_NORMAL) |=> measure_switch)
		else $error("Measure switch failed to close.");

	a_pull_gated: assert property (@(posedge mclk) disable iff (!rst_n)
		$past(measure_enable) |-> (pull_up_en[1:0] == 2'h0 && pull_down_en[1:0] == 2'h0))
		else $error("Pull active on gated input.");

	a_pull_code_up: assert property (@(posedge mclk) disable iff (!rst_n)
		(!measure_enable && pull_config_reg[5:4] == PULL_UP) |=> (pull_up_en[2] && !pull_down_en[2]))
		else $error("Pull-up code not applied.");

	a_pull_auto: assert property (@(posedge mclk) disable iff (!rst_n)
		(pull_config_reg[5:4] == PULL_AUTO) |=> (pull_up_en[2] == $past(filt_level[2]))
			&& (pull_down_en[2] != pull_up_en[2]))
		else $error("Automatic pull does not follow level.");

	a_flags_frozen: assert property (@(posedge mclk) disable iff (!rst_n)
		(measure_enable && wake_flags_clear[1:0] == 2'h0) |=> !$rose(wake_flags_primary[0])
			&& !$rose(wake_flags_primary[1]))
		else $error("Gated input flag updated.");

	a_level_frozen: assert property (@(posedge mclk) disable iff (!rst_n)
		measure_enable |=> (pin_level_status[1:0] == $past(pin_level_status[1:0])))
		else $error("Gated input level status updated.");

	a_sleep_fault: assert property (@(posedge mclk) disable iff (!rst_n)
		(sleep_cmd && measure_enable && wake_enable_reg == 3'h1) |=> (cmd_fault && restart_req))
		else $error("Sleep check missed fault.");

	a_restart_cause: assert property (@(posedge mclk) disable iff (!rst_n)
		!sleep_cmd |=> !restart_req)
		else $error("Restart requested without a sleep command.");

	a_wake_interrupt: assert property (@(posedge mclk) disable iff (!rst_n)
		(filt_edge[2] && wake_enable_reg[2] && normal_or_stop) |=> (wake_int_req && wake_flags_primary[2]))
		else $error("Wake edge did not raise interrupt.");

	a_wake_from_sleep: assert property (@(posedge mclk) disable iff (!rst_n)
		(filt_edge[2] && wake_enable_reg[2] && op_mode == WKC_MODE_SLEEP) |=> wake_up_req)
		else $error("Wake edge did not wake from sleep.");
endmodule

// ===== tb/wkc_top_bench.sv
/*
 * Self-checking bench for the wake input block.
 * Assumes a 20 MHz clock and a switch model at the pins.
 */
`timescale 1ns/1ns
module wkc_top_bench;
	import wkc_pkg::*;
	logic       mclk, rst_n, measure_enable, sleep_cmd, t1, t2;
	logic [5:0] pull_cfg, filt_cfg;
	logic [2:0] wake_en, clr, drv_en, drv_lvl, comp_in, pu, pd, flags, lvl;
	logic       msw, wint, wup, fault, rreq;
	wkc_mode_e  op_mode;
	int         err_count, checks, int_cnt, wup_cnt, rst_cnt;

	// ==========================================
	// Design and pin model
	wkc_top wkc_top_inst (.mclk(mclk), .rst_n(rst_n), .comp_in(comp_in), .pull_config_reg(pull_cfg),
		.filter_config_reg(filt_cfg), .wake_enable_reg(wake_en), .measure_enable(measure_enable),
		.op_mode(op_mode), .sleep_cmd(sleep_cmd), .cycle_timer_one_sample(t1), .cycle_timer_two_sample(t2),
		.wake_flags_clear(clr), .pull_up_en(pu), .pull_down_en(pd), .measure_switch(msw),
		.wake_flags_primary(flags), .pin_level_status(lvl), .wake_int_req(wint), .wake_up_req(wup),
		.cmd_fault(fault), .restart_req(rreq));
	wkc_wake_switch wkc_wake_switch_inst (.mclk(mclk), .pull_up_en(pu), .pull_down_en(pd),
		.drive_en(drv_en), .drive_lvl(drv_lvl), .comp_in(comp_in));

	initial begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end

	// Pulses last one cycle, so they are counted here rather than polled.
	always @(posedge mclk) begin
		if (rst_n) begin
			int_cnt += wint;
			wup_cnt += wup;
			rst_cnt += rreq;
		end
	end

	// ==========================================
	// Tasks
	task automatic end_sim();
		if (err_count == 0 && checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
			err_count++;
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(negedge mclk);
	endtask

	// A flag that never comes within its bound ends the run.
	task automatic wait_flag(input int i, input int bound);
		for (int k = 0; k < bound; k++) begin
			@(negedge mclk);
			if (flags[i] === 1'b1) return;
		end
		$display("BAD t=%0t seen=%h exp=%h", $time, 1'b0, 1'b1);
		err_count++;
		end_sim();
	endtask

	task automatic clear_flags();
		clr = 3'h7;
		cyc(1);
		clr = 3'h0;
		cyc(1);
	endtask

	// ==========================================
	// Scenarios
	initial begin
		logic [1:0] exp_pull [3];
		exp_pull = '{2'h0, 2'h1, 2'h2};
		rst_n = 1'b0; measure_enable = 1'b0; sleep_cmd = 1'b0; t1 = 1'b0; t2 = 1'b0;
		pull_cfg = 6'h00; filt_cfg = 6'h00; wake_en = 3'h0; clr = 3'h0; drv_en = 3'h0; drv_lvl = 3'h0;
		op_mode = WKC_MODE_NORMAL;
		err_count = 0; checks = 0;
		repeat (8) @(posedge mclk);
		@(negedge mclk);
		rst_n = 1'b1;
		cyc(1);
		chk({msw, flags, lvl, fault}, 32'h0000_0000);
		for (int c = 0; c < 3; c++) begin
			pull_cfg[5:4] = c[1:0];
			cyc(3);
			chk({pu[2], pd[2]}, exp_pull[c]);
		end
		pull_cfg[5:4] = PULL_AUTO;
		cyc(3);
		chk({pu[2], pd[2]}, 2'h1);
		wake_en = 3'h4;
		drv_en = 3'h4; drv_lvl = 3'h4;
		cyc(100);
		drv_lvl = 3'h0;
		cyc(400);
		chk(flags, 3'h0);
		drv_lvl = 3'h4;
		cyc(300);
		chk(flags, 3'h0);
		wait_flag(2, 40);
		cyc(2);
		chk({int_cnt[3:0], lvl[2], pu[2], pd[2]}, 7'h0E);
		clear_flags();
		filt_cfg[5:4] = DET_STATIC_LONG;
		drv_lvl = 3'h0;
		cyc(1250);
		chk(flags, 3'h0);
		wait_flag(2, 80);
		cyc(2);
		chk({int_cnt[3:0], lvl[2]}, 5'h04);
		// Cyclic sense: no flag while the selected timer strobe is low; the bench then holds the strobe high.
		clear_flags();
		filt_cfg[5:4] = DET_CYCLIC_ONE;
		drv_lvl = 3'h4;
		cyc(400);
		chk(flags, 3'h0);
		t1 = 1'b1;
		wait_flag(2, 340);
		clear_flags();
		filt_cfg[5:4] = DET_CYCLIC_TWO;
		drv_lvl = 3'h0;
		cyc(400);
		chk(flags, 3'h0);
		t2 = 1'b1;
		wait_flag(2, 340);
		clear_flags();
		filt_cfg[5:4] = DET_STATIC_SHORT;
		op_mode = WKC_MODE_SLEEP;
		drv_lvl = 3'h4;
		wait_flag(2, 340);
		cyc(2);
		chk(wup_cnt, 32'h0000_0001);
		op_mode = WKC_MODE_NORMAL;
		pull_cfg[1:0] = PULL_UP;
		cyc(3);
		chk(pu[0], 1'b1);
		measure_enable = 1'b1;
		cyc(3);
		chk({msw, pu[0], pd[0]}, 3'h4);
		wake_en = 3'h5;
		drv_en = 3'h5; drv_lvl = 3'h5;
		cyc(400);
		chk({flags[0], lvl[0]}, 2'h0);
		op_mode = WKC_MODE_STOP;
		cyc(2);
		chk(msw, 1'b0);
		op_mode = WKC_MODE_NORMAL;
		wake_en = 3'h5;
		sleep_cmd = 1'b1;
		cyc(1);
		sleep_cmd = 1'b0;
		cyc(2);
		chk({fault, rst_cnt[3:0]}, 5'h00);
		wake_en = 3'h1;
		sleep_cmd = 1'b1;
		cyc(1);
		sleep_cmd = 1'b0;
		cyc(2);
		chk({fault, rst_cnt[3:0]}, 5'h11);
		measure_enable = 1'b0;
		cyc(2);
		chk(msw, 1'b0);
		wait_flag(0, 340);
		end_sim();
	end
endmodule

// ===== tb/wkc_wake_switch.sv
/*
 * Model of the external wake switch or sensor at each wake pin.
 * Assumes the bench says when the switch drives the pin and to which level.
 */
`timescale 1ns/1ns
module wkc_wake_switch
	import wkc_pkg::*;
(
	input  wire logic                             mclk,
	input  wire logic [wkc_pkg::NUM_INPUTS-1:0]   pull_up_en,
	input  wire logic [wkc_pkg::NUM_INPUTS-1:0]   pull_down_en,
	input  wire logic [wkc_pkg::NUM_INPUTS-1:0]   drive_en,
	input  wire logic [wkc_pkg::NUM_INPUTS-1:0]   drive_lvl,
	output logic      [wkc_pkg::NUM_INPUTS-1:0]   comp_in
);
	// ==========================================
	// Pin level
	// An open pin without pull current wanders, so it toggles every cycle.
	initial comp_in = 3'h0;
	always @(posedge mclk) begin
		for (int i = 0; i < NUM_INPUTS; i++) begin
			if (drive_en[i]) begin
				comp_in[i] <= drive_lvl[i];
			end else if (pull_up_en[i]) begin
				comp_in[i] <= 1'b1;
			end else if (pull_down_en[i]) begin
				comp_in[i] <= 1'b0;
			end else begin
				comp_in[i] <= ~comp_in[i];
			end
		end
	end
endmodule
